// *** bpih_cfg_store.sv ***
// Word store for the preloaded bridge configuration registers.
// Assumes indices below the entry count; read data is registered.
`timescale 1ns/1ps
module bpih_cfg_store #(
	parameter int unsigned N = bpih_pkg::CFG_N
) (
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	input  wire logic                        we,
	input  wire logic [bpih_pkg::CIDX_W-1:0] wIdx,
	input  wire logic [31:0]                 wData,
	input  wire logic                        re,
	input  wire logic [bpih_pkg::CIDX_W-1:0] rIdx,
	output logic      [31:0]                 rData
);
	import bpih_pkg::*;

	logic [31:0] word_ff [N];
	logic [31:0] rData_ff;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_word
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					word_ff[gi] <= CFG_RST[gi];
				end else if (we && wIdx == CIDX_W'(gi)) begin
					word_ff[gi] <= wData;
				end
			end
		end
	endgenerate

	// Out-of-range index reads zero rather than an undefined entry
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rData_ff <= 32'h00000000;
		end else if (re) begin
			rData_ff <= (rIdx < CIDX_W'(N)) ? word_ff[rIdx] : 32'h00000000;
		end
	end

	assign rData = rData_ff;

endmodule // bpih_cfg_store

// *** bpih_handshake.sv ***
// Endpoint-side peer init handshake controller with AHB-Lite registers.
// Assumes the root doorbell is a one-cycle pulse synchronous to mclk.
// Function
// - Start in down; on init publish inbound address and state code.
// - After publishing init, ring the doorbell toward the root.
// - Init work proceeds only on a root notification reporting init.
// - Load translation bases 0 and 1 from inbound messages 1 and 2.
// - Keep shared words 0 and 1 as peer inbound and config bases.
// - After recording the root, stay idle until a root notification reporting map.
// - On root map, take peer index from message 3, enter map, interrupt.
// - Peer identifier is the external endpoint bus, device, function number.
// - On root ok, set up transmit queue, enter ok, interrupt the root.
// - Data transfer is enabled only in the ok state.
// - In ok, root removal clears outbound messages and nulls peer index.
// - After removal drop peer data, go to init, await fresh root interrupt.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module bpih_handshake (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire bpih_pkg::bpih_inbound_t    rootMsg,
	input  wire logic                       rootDoorbell,
	input  wire logic [bpih_pkg::BDF_W-1:0] extBdf,
	output bpih_pkg::bpih_outbound_t        endpointMsg,
	output logic                            endpointDoorbell,
	output logic      [31:0]                transBase0,
	output logic      [31:0]                transBase1,
	output logic                            xferEnable,
	output logic                            irq
);
	import bpih_pkg::*;

	bpih_state_t     state_ff;
	bpih_state_t     nxt_state;
	bpih_outbound_t  outMsg_ff;
	logic            doorbell_ff;
	logic [31:0]     tBase0_ff;
	logic [31:0]     tBase1_ff;
	logic [31:0]     shared0_ff;
	logic [31:0]     shared1_ff;
	logic            peerKnown_ff;
	logic [PIDX_W-1:0] peerIdx_ff;
	logic [BDF_W-1:0]  peerId_ff;
	logic            xfer_ff;
	logic [31:0]     ibAddr_ff;
	logic            pend_ff;
	logic            write_ff;
	logic [31:0]     addr_ff;
	logic            cfgHit_ff;
	logic [CIDX_W-1:0] cfgIdx_ff;
	logic            hreadyout_ff;
	logic            hresp_ff;
	logic [31:0]     hrdata_ff;

	logic              accept;
	logic              wrEn;
	logic              rdEn;
	logic [CIDX_W:0]   cfgLook;
	logic [31:0]       cfgRdata;
	logic [EV_W-1:0]   evStatus;
	logic [EV_W-1:0]   evMask;
	logic [EV_W-1:0]   events;
	logic              startReq;
	logic              capture;
	logic              mapGo;
	logic              okGo;
	logic              removeGo;
	logic              republish;
	logic              badNotify;
	logic [31:0]       rootCode;

	function automatic logic [CIDX_W:0] cfgLookup(input logic [31:0] a);
		logic [CIDX_W:0] r;
		r = '0;
		for (int i = 0; i < CFG_N; i++) begin
			if (a[31:ADDR_W] == '0 && a[ADDR_W-1:0] == CFG_OFF[i]) begin
				r = {1'b1, CIDX_W'(i)};
			end
		end
		return r;
	endfunction

	// Bus front: one wait state so read data can come from a flop
	assign accept  = hsel && htrans[1] && hready;
	assign wrEn    = pend_ff && write_ff;
	assign rdEn    = pend_ff && !write_ff;
	assign cfgLook = cfgLookup(haddr);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pend_ff      <= 1'b0;
			hreadyout_ff <= 1'b1;
			hresp_ff     <= 1'b0;
		end else begin
			pend_ff      <= accept;
			hreadyout_ff <= !accept;
			hresp_ff     <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			write_ff  <= 1'b0;
			addr_ff   <= 32'h00000000;
			cfgHit_ff <= 1'b0;
			cfgIdx_ff <= '0;
		end else if (accept) begin
			write_ff  <= hwrite;
			addr_ff   <= haddr;
			cfgHit_ff <= cfgLook[CIDX_W];
			cfgIdx_ff <= cfgLook[CIDX_W-1:0];
		end
	end

	bpih_cfg_store #(
		.N(CFG_N)
	) u_cfg (
		.mclk  (mclk),
		.resetn(resetn),
		.we    (wrEn && cfgHit_ff),
		.wIdx  (cfgIdx_ff),
		.wData (hwdata),
		.re    (accept && !hwrite),
		.rIdx  (cfgLook[CIDX_W-1:0]),
		.rData (cfgRdata)
	);

	// Unmapped reads return zero, writes are dropped, answer stays OKAY
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (rdEn) begin
			if (cfgHit_ff) begin
				hrdata_ff <= cfgRdata;
			end else if (addr_ff[31:ADDR_W] != '0) begin
				hrdata_ff <= 32'h00000000;
			end else begin
				case (addr_ff[ADDR_W-1:0])
					REG_STATUS:   hrdata_ff <= {26'h0000000, peerKnown_ff, xfer_ff,
					                            1'b0, state_ff};
					REG_IBADDR:   hrdata_ff <= ibAddr_ff;
					REG_PEER:     hrdata_ff <= {peerId_ff, 8'h00, peerIdx_ff};
					REG_TBASE0:   hrdata_ff <= tBase0_ff;
					REG_TBASE1:   hrdata_ff <= tBase1_ff;
					REG_SHARED0:  hrdata_ff <= shared0_ff;
					REG_SHARED1:  hrdata_ff <= shared1_ff;
					REG_IRQ_STAT: hrdata_ff <= {26'h0000000, evStatus};
					REG_IRQ_MASK: hrdata_ff <= {26'h0000000, evMask};
					default:      hrdata_ff <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ibAddr_ff <= 32'h00000000;
		end else if (wrEn && addr_ff == {18'h00000, REG_IBADDR}) begin
			ibAddr_ff <= hwdata;
		end
	end

	assign startReq = wrEn && addr_ff == {18'h00000, REG_CTRL} && hwdata[CTRL_START_BIT];

	// Handshake decode; the root drives its own state into message 0
	assign rootCode  = rootMsg.msg0;
	assign capture   = state_ff == ST_WINIT && rootDoorbell && rootCode == CODE_INIT;
	assign mapGo     = state_ff == ST_IDLE && rootDoorbell && rootCode == CODE_MAP;
	assign okGo      = state_ff == ST_MAP && rootDoorbell && rootCode == CODE_OK;
	assign removeGo  = state_ff == ST_OK && rootDoorbell && rootCode == CODE_REMOVE;
	assign republish = state_ff == ST_REINIT && rootDoorbell && rootCode == CODE_INIT;
	assign badNotify = rootDoorbell && !(capture || mapGo || okGo || removeGo || republish);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_DOWN:   if (startReq) nxt_state = ST_PUB;
			ST_PUB:    nxt_state = ST_RING;
			ST_RING:   nxt_state = ST_WINIT;
			ST_WINIT:  if (capture) nxt_state = ST_IDLE;
			ST_IDLE:   if (mapGo) nxt_state = ST_MAP;
			ST_MAP:    if (okGo) nxt_state = ST_OK;
			ST_OK:     if (removeGo) nxt_state = ST_REINIT;
			ST_REINIT: if (republish) nxt_state = ST_PUB;
			default:   nxt_state = ST_DOWN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_ff <= ST_DOWN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outbound messages; message 0 carries our own state code until root removal clears it to zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			outMsg_ff      <= '0;
			outMsg_ff.msg0 <= CODE_DOWN;
		end else if (removeGo) begin
			outMsg_ff <= '0;
		end else if (state_ff == ST_PUB) begin
			outMsg_ff.msg1 <= ibAddr_ff;
			outMsg_ff.msg0 <= CODE_INIT;
		end else if (mapGo) begin
			outMsg_ff.msg0 <= CODE_MAP;
		end else if (okGo) begin
			outMsg_ff.msg0 <= CODE_OK;
		end
	end

	// Doorbell rings one cycle after the init message is in place, and in the same cycle as the map or ok code
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			doorbell_ff <= 1'b0;
		end else begin
			doorbell_ff <= state_ff == ST_RING || mapGo || okGo;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tBase0_ff    <= 32'h00000000;
			tBase1_ff    <= 32'h00000000;
			shared0_ff   <= 32'h00000000;
			shared1_ff   <= 32'h00000000;
			peerKnown_ff <= 1'b0;
		end else if (removeGo) begin
			tBase0_ff    <= 32'h00000000;
			tBase1_ff    <= 32'h00000000;
			shared0_ff   <= 32'h00000000;
			shared1_ff   <= 32'h00000000;
			peerKnown_ff <= 1'b0;
		end else if (capture) begin
			tBase0_ff    <= rootMsg.msg1;
			tBase1_ff    <= rootMsg.msg2;
			shared0_ff   <= rootMsg.shared0;
			shared1_ff   <= rootMsg.shared1;
			peerKnown_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			peerIdx_ff <= PEER_NULL;
			peerId_ff  <= '0;
		end else if (removeGo) begin
			peerIdx_ff <= PEER_NULL;
			peerId_ff  <= '0;
		end else if (mapGo) begin
			peerIdx_ff <= rootMsg.msg3[PIDX_W-1:0];
			peerId_ff  <= extBdf;
		end
	end

	// Transmit queue readiness doubles as the transfer enable
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			xfer_ff <= 1'b0;
		end else if (removeGo) begin
			xfer_ff <= 1'b0;
		end else if (okGo) begin
			xfer_ff <= 1'b1;
		end
	end

	assign events = {badNotify, removeGo, okGo, mapGo, capture, rootDoorbell};

	bpih_irq u_irq (
		.mclk     (mclk),
		.resetn   (resetn),
		.events   (events),
		.maskWe   (wrEn && addr_ff == {18'h00000, REG_IRQ_MASK}),
		.maskWdata(hwdata[EV_W-1:0]),
		.statRd   (rdEn && addr_ff == {18'h00000, REG_IRQ_STAT}),
		.status   (evStatus),
		.mask     (evMask),
		.irq      (irq)
	);

	assign hrdata           = hrdata_ff;
	assign hreadyout        = hreadyout_ff;
	assign hresp            = hresp_ff;
	assign endpointMsg      = outMsg_ff;
	assign endpointDoorbell = doorbell_ff;
	assign transBase0       = tBase0_ff;
	assign transBase1       = tBase1_ff;
	assign xferEnable       = xfer_ff;

	a_down_after_reset: assert property (@(posedge mclk)
		$rose(resetn) |-> state_ff == ST_DOWN && outMsg_ff.msg0 == CODE_DOWN)
		else $error("not down after reset");
	a_publish_init: assert property (@(posedge mclk) disable iff (!resetn)
		state_ff == ST_PUB |=> outMsg_ff.msg0 == CODE_INIT && outMsg_ff.msg1 == $past(ibAddr_ff))
		else $error("init not published");
	a_ring_after_pub: assert property (@(posedge mclk) disable iff (!resetn)
		state_ff == ST_PUB |=> !doorbell_ff ##1 doorbell_ff && outMsg_ff.msg0 == CODE_INIT)
		else $error("doorbell not rung after init");
	a_init_gate: assert property (@(posedge mclk) disable iff (!resetn)
		state_ff == ST_WINIT && !(rootDoorbell && rootCode == CODE_INIT) |=> state_ff == ST_WINIT)
		else $error("left init wait without root init");
	a_base_load: assert property (@(posedge mclk) disable iff (!resetn)
		capture |=> tBase0_ff == $past(rootMsg.msg1) && tBase1_ff == $past(rootMsg.msg2))
		else $error("translation bases not loaded");
	a_shared_keep: assert property (@(posedge mclk) disable iff (!resetn)
		capture |=> shared0_ff == $past(rootMsg.shared0) && shared1_ff == $past(rootMsg.shared1)
		&& peerKnown_ff)
		else $error("shared words not kept");
	a_idle_hold: assert property (@(posedge mclk) disable iff (!resetn)
		state_ff == ST_IDLE && !rootDoorbell |=> state_ff == ST_IDLE && $stable(outMsg_ff))
		else $error("advanced without notification");
	a_map_entry: assert property (@(posedge mclk) disable iff (!resetn)
		mapGo |=> state_ff == ST_MAP && doorbell_ff && outMsg_ff.msg0 == CODE_MAP
		&& peerIdx_ff == $past(rootMsg.msg3[PIDX_W-1:0]))
		else $error("map entry wrong");
	a_peer_id: assert property (@(posedge mclk) disable iff (!resetn)
		mapGo |=> peerId_ff == $past(extBdf))
		else $error("peer id not formed");
	a_ok_entry: assert property (@(posedge mclk) disable iff (!resetn)
		okGo |=> state_ff == ST_OK && doorbell_ff && xfer_ff && outMsg_ff.msg0 == CODE_OK)
		else $error("ok entry wrong");
	a_xfer_only_ok: assert property (@(posedge mclk) disable iff (!resetn)
		xfer_ff |-> state_ff == ST_OK)
		else $error("transfer enabled outside ok");
	a_teardown: assert property (@(posedge mclk) disable iff (!resetn)
		removeGo |=> outMsg_ff == '0 && peerIdx_ff == PEER_NULL && !peerKnown_ff && !xfer_ff
		&& state_ff == ST_REINIT)
		else $error("teardown incomplete");

endmodule // bpih_handshake

// *** bpih_irq.sv ***
// Sticky event status, mask and level interrupt.
// Assumes events are one-cycle pulses; a status read clears all bits except those set again in that cycle.
`timescale 1ns/1ps
module bpih_irq (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire logic [bpih_pkg::EV_W-1:0] events,
	input  wire logic                      maskWe,
	input  wire logic [bpih_pkg::EV_W-1:0] maskWdata,
	input  wire logic                      statRd,
	output logic      [bpih_pkg::EV_W-1:0] status,
	output logic      [bpih_pkg::EV_W-1:0] mask,
	output logic                           irq
);
	import bpih_pkg::*;

	logic [EV_W-1:0] status_ff;
	logic [EV_W-1:0] mask_ff;
	logic            irq_ff;
	logic [EV_W-1:0] nxt_status;

	// Set wins over the read clear so no event is lost
	assign nxt_status = (statRd ? {EV_W{1'b0}} : status_ff) | events;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			status_ff <= {EV_W{1'b0}};
		end else begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mask_ff <= {EV_W{1'b0}};
		end else if (maskWe) begin
			mask_ff <= maskWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	assign status = status_ff;
	assign mask   = mask_ff;
	assign irq    = irq_ff;

	a_event_sticky: assert property (@(posedge mclk) disable iff (!resetn)
		(|events) |=> ((status_ff & $past(events)) == $past(events)))
		else $error("event did not set its status bit");
	a_irq_level: assert property (@(posedge mclk) disable iff (!resetn)
		(|(status_ff & mask_ff)) |=> irq_ff)
		else $error("unmasked status did not raise interrupt");

endmodule // bpih_irq

// *** bpih_pkg.sv ***
// Shared constants, types and register map of the bridge peer init handshake.
// Assumes one clock domain and a 32-bit AHB-Lite register port.
package bpih_pkg;

	localparam int unsigned ADDR_W = 14;
	localparam int unsigned EV_W   = 6;
	localparam int unsigned CFG_N  = 11;
	localparam int unsigned CIDX_W = 4;
	localparam int unsigned BDF_W  = 16;
	localparam int unsigned PIDX_W = 8;

	// Own register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL     = 14'h0000;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 14'h0004;
	localparam logic [ADDR_W-1:0] REG_IBADDR   = 14'h0008;
	localparam logic [ADDR_W-1:0] REG_PEER     = 14'h000C;
	localparam logic [ADDR_W-1:0] REG_TBASE0   = 14'h0010;
	localparam logic [ADDR_W-1:0] REG_TBASE1   = 14'h0014;
	localparam logic [ADDR_W-1:0] REG_SHARED0  = 14'h0018;
	localparam logic [ADDR_W-1:0] REG_SHARED1  = 14'h001C;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 14'h0020;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 14'h0024;

	// Field positions
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned STAT_XFER_BIT  = 4;
	localparam int unsigned STAT_PEER_BIT  = 5;
	localparam int unsigned PEER_BDF_LSB   = 16;

	// Event bits of the interrupt status
	localparam int unsigned EV_NOTIFY = 0;
	localparam int unsigned EV_INIT   = 1;
	localparam int unsigned EV_MAP    = 2;
	localparam int unsigned EV_OK     = 3;
	localparam int unsigned EV_REMOVE = 4;
	localparam int unsigned EV_BAD    = 5;

	// Published state codes; zero means a cleared message
	localparam logic [31:0] CODE_DOWN   = 32'h00000001;
	localparam logic [31:0] CODE_INIT   = 32'h00000002;
	localparam logic [31:0] CODE_MAP    = 32'h00000003;
	localparam logic [31:0] CODE_OK     = 32'h00000004;
	localparam logic [31:0] CODE_REMOVE = 32'h00000005;
	localparam logic [PIDX_W-1:0] PEER_NULL = 8'hFF;

	// Preloaded bridge configuration words
	localparam logic [31:0] SWITCH_CONTROL_RST = 32'h00000054;
	localparam logic [31:0] PORT_CAP_RST       = 32'h01000000;
	localparam logic [31:0] INTR_LINE_RST      = 32'h00000100;
	localparam logic [31:0] SIDE_CONTROL_RST   = 32'h00000000;
	localparam logic [31:0] INT_WIN0_RST       = 32'h80000140;
	localparam logic [31:0] EXT_WIN0_RST       = 32'h80000150;
	localparam logic [31:0] INT_WIN1_RST       = 32'h800001A0;
	localparam logic [31:0] WIN4_RST           = 32'h800000C0;

	localparam logic [ADDR_W-1:0] CFG_OFF [CFG_N] = '{
		14'h00A4, 14'h1040, 14'h2040, 14'h303C, 14'h383C, 14'h3078,
		14'h307C, 14'h387C, 14'h3084, 14'h309C, 14'h389C};
	localparam logic [31:0] CFG_RST [CFG_N] = '{
		SWITCH_CONTROL_RST, PORT_CAP_RST, PORT_CAP_RST, INTR_LINE_RST,
		INTR_LINE_RST, SIDE_CONTROL_RST, INT_WIN0_RST, EXT_WIN0_RST,
		INT_WIN1_RST, WIN4_RST, WIN4_RST};

	typedef enum logic [2:0] {
		ST_DOWN   = 3'b000,
		ST_PUB    = 3'b001,
		ST_RING   = 3'b010,
		ST_WINIT  = 3'b011,
		ST_IDLE   = 3'b100,
		ST_MAP    = 3'b101,
		ST_OK     = 3'b110,
		ST_REINIT = 3'b111
	} bpih_state_t;

	typedef struct packed {
		logic [31:0] msg3;
		logic [31:0] msg2;
		logic [31:0] msg1;
		logic [31:0] msg0;
		logic [31:0] shared1;
		logic [31:0] shared0;
	} bpih_inbound_t;

	typedef struct packed {
		logic [31:0] msg3;
		logic [31:0] msg2;
		logic [31:0] msg1;
		logic [31:0] msg0;
	} bpih_outbound_t;

endpackage

// *** bpih_root_model.sv ***
// Root processor model on the far side of the bridge.
// Assumes the endpoint shares mclk and samples the ring at a rising edge.
`timescale 1ns/1ps
module bpih_root_model #(
	parameter logic [31:0] TB0 = 32'h10000000,
	parameter logic [31:0] TB1 = 32'h24000000,
	parameter logic [31:0] SH0 = 32'h40000000,
	parameter logic [31:0] SH1 = 32'h48000000
) (
	input  wire logic               mclk,
	output bpih_pkg::bpih_inbound_t rootMsg,
	output logic                    rootDoorbell
);
	import bpih_pkg::*;
	initial begin
		rootMsg = '{msg3: 32'h00000000, msg2: TB1, msg1: TB0, msg0: CODE_DOWN,
			shared1: SH1, shared0: SH0};
		rootDoorbell = 1'b0;
	end
	// Code and index change with the ring, so no half update is ever seen
	task automatic notify(input logic [31:0] code, input logic [7:0] idx);
		@(posedge mclk);
		rootMsg.msg0 <= code;
		rootMsg.msg3 <= {24'h000000, idx};
		rootDoorbell <= 1'b1;
		@(posedge mclk);
		rootDoorbell <= 1'b0;
	endtask
endmodule // bpih_root_model

// *** tb.sv ***
// Self-checking bench for the endpoint handshake block.
// Assumes the root model drives the inbound side; one AHB master.
`timescale 1ns/1ps
module tb;
	import bpih_pkg::*;
	localparam logic [31:0] TB0 = 32'h10000000;
	localparam logic [31:0] TB1 = 32'h24000000;
	localparam logic [31:0] SH0 = 32'h40000000;
	localparam logic [31:0] SH1 = 32'h48000000;
	localparam logic [31:0] IBA = 32'h00ABC000;
	localparam logic [15:0] BDF = 16'h0200;
	logic           mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic           rootDoorbell, endpointDoorbell, xferEnable, irq;
	logic [31:0]    haddr, hwdata, hrdata, transBase0, transBase1, rd;
	logic [1:0]     htrans;
	logic [2:0]     hsize;
	logic [15:0]    extBdf;
	bpih_inbound_t  rootMsg;
	bpih_outbound_t endpointMsg;
	int             fails, comparisons;

	assign hready = hreadyout;
	bpih_handshake DUT (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rootMsg(rootMsg),
		.rootDoorbell(rootDoorbell), .extBdf(extBdf), .endpointMsg(endpointMsg),
		.endpointDoorbell(endpointDoorbell), .transBase0(transBase0),
		.transBase1(transBase1),
		.xferEnable(xferEnable), .irq(irq));
	bpih_root_model #(.TB0(TB0), .TB1(TB1), .SH0(SH0), .SH1(SH1)) root (.mclk(mclk),
		.rootMsg(rootMsg), .rootDoorbell(rootDoorbell));

	always #10 mclk = ~mclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	// Single word transfer; waits on the slave's ready, never on a fixed count
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0, "okay response");
	endtask
	task automatic rings(input int span, input logic [31:0] exp, input string what);
		logic [31:0] n;
		n = 32'h0;
		for (int i = 0; i < span; i++) begin
			@(posedge mclk);
			if (endpointDoorbell === 1'b1) n++;
		end
		check(n, exp, what);
	endtask
	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask

	task automatic t_reset();
		logic [31:0] offs [5];
		logic [31:0] vals [5];
		offs = '{32'h00A4, 32'h1040, 32'h2040, 32'h3084, 32'h309C};
		vals = '{32'h00000054, 32'h01000000, 32'h01000000, 32'h800001A0, 32'h800000C0};
		check(endpointMsg.msg0, CODE_DOWN, "down code");
		for (int i = 0; i < 5; i++) begin
			ahb(1'b0, offs[i], 32'h0);
			check(rd, vals[i], "preload word");
		end
		ahb(1'b1, 32'h309C, 32'h800000D0);
		ahb(1'b0, 32'h309C, 32'h0);
		check(rd, 32'h800000D0, "config word rw");
		ahb(1'b1, 32'h0100, 32'hFFFFFFFF);
		ahb(1'b0, 32'h0100, 32'h0);
		check(rd, 32'h00000000, "unmapped read");
		$display("t_reset done");
	endtask
	task automatic t_start();
		ahb(1'b1, 32'(REG_IRQ_MASK), 32'h0000003F);
		ahb(1'b1, 32'(REG_IBADDR), IBA);
		ahb(1'b1, 32'(REG_CTRL), 32'h00000001);
		rings(20, 32'h1, "init ring");
		check(endpointMsg.msg1, IBA, "inbound address");
		check(endpointMsg.msg0, CODE_INIT, "init code");
		$display("t_start done");
	endtask
	task automatic t_init();
		root.notify(CODE_MAP, 8'h00);
		settle();
		check(transBase0, 32'h0, "early capture");
		ahb(1'b0, 32'(REG_IRQ_STAT), 32'h0);
		check(rd, 32'h00000021, "unexpected code event");
		settle();
		check({31'h0, irq}, 32'h0, "irq after clear");
		root.notify(CODE_INIT, 8'h00);
		settle();
		check(transBase0, TB0, "base 0");
		check(transBase1, TB1, "base 1");
		check({31'h0, irq}, 32'h1, "irq raised");
		ahb(1'b0, 32'(REG_SHARED0), 32'h0);
		check(rd, SH0, "shared 0");
		ahb(1'b0, 32'(REG_SHARED1), 32'h0);
		check(rd, SH1, "shared 1");
		ahb(1'b0, 32'(REG_IRQ_STAT), 32'h0);
		check(rd, 32'h00000003, "init events");
		rings(30, 32'h0, "idle ring");
		ahb(1'b0, 32'(REG_STATUS), 32'h0);
		check({29'h0, rd[2:0]}, 32'h4, "idle state");
		check({31'h0, rd[5]}, 32'h1, "peer recorded");
		$display("t_init done");
	endtask
	task automatic t_map_ok();
		ahb(1'b1, 32'(REG_IRQ_MASK), 32'h0);
		root.notify(CODE_MAP, 8'h07);
		rings(20, 32'h1, "map ring");
		check(endpointMsg.msg0, CODE_MAP, "map code");
		ahb(1'b0, 32'(REG_PEER), 32'h0);
		check(rd, {BDF, 16'h0007}, "peer id and index");
		check({31'h0, irq}, 32'h0, "masked irq");
		check({31'h0, xferEnable}, 32'h0, "no transfer in map");
		ahb(1'b1, 32'(REG_IRQ_MASK), 32'h0000003F);
		settle();
		check({31'h0, irq}, 32'h1, "unmasked irq");
		ahb(1'b0, 32'(REG_IRQ_STAT), 32'h0);
		check(rd, 32'h00000005, "map events");
		root.notify(CODE_OK, 8'h07);
		rings(20, 32'h1, "ok ring");
		check(endpointMsg.msg0, CODE_OK, "ok code");
		check({31'h0, xferEnable}, 32'h1, "transfer in ok");
		$display("t_map_ok done");
	endtask
	task automatic t_remove();
		root.notify(CODE_REMOVE, 8'h07);
		settle();
		check(32'(endpointMsg != '0), 32'h0, "cleared out");
		ahb(1'b0, 32'(REG_PEER), 32'h0);
		check({24'h0, rd[7:0]}, 32'h000000FF, "null index");
		check({31'h0, xferEnable}, 32'h0, "transfer off");
		check(transBase0, 32'h0, "peer data dropped");
		rings(20, 32'h0, "no restart alone");
		root.notify(CODE_INIT, 8'h00);
		rings(20, 32'h1, "restart ring");
		check(endpointMsg.msg0, CODE_INIT, "republished");
		$display("t_remove done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		extBdf = BDF;
		fails = 0;
		comparisons = 0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_start();
		t_init();
		t_map_ok();
		t_remove();
		wrap_up();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule // tb
